// ===== core/mssp_defs.svh
// Constants of the motion sensor serial port
`ifndef MSSP_DEFS_SVH
`define MSSP_DEFS_SVH

// Clock rate in kHz
`define MSSP_CLK_KHZ        200000
// Downshift times in ms
`define MSSP_DSHIFT1_MS     237
`define MSSP_DSHIFT2_MS     8400
`define MSSP_DSHIFT3_MS     504000
// Poll periods in ms
`define MSSP_POLL1_MS       33
`define MSSP_POLL2_MS       164
`define MSSP_POLL3_MS       840
// Cycles per ms
`define MSSP_CYC_PER_MS     (`MSSP_CLK_KHZ)
// Address of the motion status register
`define MSSP_ADDR_MOTION    7'h02
`define MSSP_ADDR_DX        7'h03
`define MSSP_ADDR_DY        7'h04
`define MSSP_ADDR_SQUAL     7'h05
`define MSSP_ADDR_BURST     7'h42
// Motion status bit position
`define MSSP_MOT_BIT        7
// Write marker bit of the address byte
`define MSSP_WR_BIT         7
// Index of the last burst byte
`define MSSP_BURST_LAST     3'h6
// Laser flash length in cycles
`define MSSP_FLASH_CYC      16'h0040
`define MSSP_BITS_LAST      3'h7

`endif

// ===== core/mssp_pkg.sv
// Types of the motion sensor serial port
package mssp_pkg;
    typedef enum logic [4:0] {
        MSSP_IDLE  = 5'h01,
        MSSP_ADDR  = 5'h02,
        MSSP_WDATA = 5'h04,
        MSSP_RDATA = 5'h08,
        MSSP_DONE  = 5'h10
    } mssp_port_type;

    typedef enum logic [3:0] {
        MSSP_RUN   = 4'h1,
        MSSP_REST1 = 4'h2,
        MSSP_REST2 = 4'h4,
        MSSP_REST3 = 4'h8
    } mssp_pwr_type;
endpackage

// ===== core/mssp_port.sv
// Serial slave port of the motion sensor with motion indication
`timescale 1ns/100ps
`include "mssp_defs.svh"
// Summary of operation
// - Three rest levels entered after 237 ms, 8.4 s and 504 s without motion.
// - Rest levels poll for motion every 33 ms, 164 ms and 840 ms.
// - Motion output held low while the motion flag is set.
// - Flag clears after both displacements read, or a motion register write.
// - Laser flashes only when a capture needs it.
// - Only the host starts transfers and drives the serial clock.
// - Chip select high: clock and data ignored, data out released.
// - Port enabled only after chip select falls.
// - Chip select rising mid transfer aborts it and idles the port.
// - After a burst the port is refused until chip select rises.
// - Write is address byte with top bit one, then data byte.
// - Data in sampled on rising serial clock edges.
// - Read is address byte with top bit zero, then device data byte.
// - Read data bits change on falling serial clock edges.
// - Last read bit held until the next falling clock edge.
// - Burst returns status, displacements and more; may stop after X.
module mssp_port (
    // Clock, reset and enable
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        clkEn,
    // Serial link pins
    input  wire logic        chip_select_low,
    input  wire logic        serClk,
    input  wire logic        serDataIn,
    output logic             serDataOut,
    output logic             serDataOutEn_n,
    // Motion indication and laser
    output logic             motion_n,
    output logic             laserOn,
    // Navigation core side
    input  wire logic        motionSeen,
    input  wire logic [7:0]  deltaX,
    input  wire logic [7:0]  deltaY,
    input  wire logic [7:0]  surfQual,
    output logic             captureReq,
    output logic [3:0]       powerLevel
);
    // ************************************************
    // State
    // ************************************************
    typedef struct packed {
        logic [1:0]                 csSync;
        logic [1:0]                 clkSync;
        logic [1:0]                 dinSync;
        logic                       clkPrev;
        logic                       csPrev;
        mssp_pkg::mssp_port_type    phase;
        logic [2:0]                 bitCnt;
        logic [7:0]                 shiftIn;
        logic [7:0]                 shiftOut;
        logic [6:0]                 addr;
        logic                       burst;
        logic [2:0]                 burstIdx;
        logic                       motFlag;
        logic                       readX;
        logic                       readY;
        logic [7:0]                 holdX;
        logic [7:0]                 holdY;
        logic                       dout;
        logic                       doutEn_n;
        logic                       motOut_n;
    } mssp_state_type;

    mssp_state_type st;
    mssp_state_type next_st;

    logic                   pwrCap;
    logic                   pwrLaser;
    mssp_pkg::mssp_pwr_type pwrLevel;
    logic                   laserReg;
    logic                   capReg;
    logic [3:0]             levelReg;

    // Byte returned for an address or burst slot
    function automatic logic [7:0] readByte(input logic [6:0] a,
                                            input mssp_state_type s);
        case (a)
            `MSSP_ADDR_MOTION: readByte = {s.motFlag, 7'h00};
            `MSSP_ADDR_DX:     readByte = s.holdX;
            `MSSP_ADDR_DY:     readByte = s.holdY;
            `MSSP_ADDR_SQUAL:  readByte = surfQual;
            default:           readByte = 8'h00;
        endcase
    endfunction

    // Burst slot index to address
    function automatic logic [6:0] burstAddr(input logic [2:0] i);
        burstAddr = `MSSP_ADDR_MOTION + {4'h0, i};
    endfunction

    // ************************************************
    // Next state
    // ************************************************
    always_comb begin
        logic csActive;
        logic rise;
        logic fall;
        logic csRise;
        logic [7:0] byteIn;
        csActive = 1'b0;
        rise     = 1'b0;
        fall     = 1'b0;
        csRise   = 1'b0;
        byteIn   = 8'h00;
        next_st  = st;
        // Two flops before any logic reads the pins
        next_st.csSync  = {st.csSync[0], chip_select_low};
        next_st.clkSync = {st.clkSync[0], serClk};
        next_st.dinSync = {st.dinSync[0], serDataIn};
        next_st.clkPrev = st.clkSync[1];
        next_st.csPrev  = st.csSync[1];
        csActive = !st.csSync[1];
        csRise   = st.csSync[1] && !st.csPrev;
        rise     = csActive && st.clkSync[1] && !st.clkPrev;
        fall     = csActive && !st.clkSync[1] && st.clkPrev;
        byteIn   = {st.shiftIn[6:0], st.dinSync[1]};

        // Latch new displacement; holding regs keep it until the next motion
        if (motionSeen) begin
            next_st.motFlag = 1'b1;
            next_st.holdX   = deltaX;
            next_st.holdY   = deltaY;
            next_st.readX   = 1'b0;
            next_st.readY   = 1'b0;
        end

        if (!csActive) begin
            // Idle and released output while deselected
            next_st.phase    = mssp_pkg::MSSP_IDLE;
            next_st.doutEn_n = 1'b1;
            next_st.bitCnt   = 3'h0;
            next_st.burst    = 1'b0;
        end else begin
            case (st.phase)
                mssp_pkg::MSSP_IDLE: begin
                    // Enabled only on a fresh falling chip select
                    if (st.csPrev) begin
                        next_st.phase = mssp_pkg::MSSP_ADDR;
                    end
                end
                mssp_pkg::MSSP_ADDR: begin
                    if (rise) begin
                        next_st.shiftIn = byteIn;
                        next_st.bitCnt  = st.bitCnt + 3'h1;
                        if (st.bitCnt == `MSSP_BITS_LAST) begin
                            next_st.addr   = byteIn[6:0];
                            next_st.bitCnt = 3'h0;
                            if (byteIn[`MSSP_WR_BIT]) begin
                                next_st.phase = mssp_pkg::MSSP_WDATA;
                            end else begin
                                next_st.phase    = mssp_pkg::MSSP_RDATA;
                                next_st.burst    = byteIn[6:0] == `MSSP_ADDR_BURST;
                                next_st.burstIdx = 3'h0;
                                // Data latched as soon as address ends
                                if (byteIn[6:0] == `MSSP_ADDR_BURST) begin
                                    next_st.shiftOut = readByte(burstAddr(3'h0), st);
                                end else begin
                                    next_st.shiftOut = readByte(byteIn[6:0], st);
                                end
                            end
                        end
                    end else if (fall) begin
                        // Falling edge starts next command; release data out
                        next_st.doutEn_n = 1'b1;
                    end
                end
                mssp_pkg::MSSP_WDATA: begin
                    if (rise) begin
                        next_st.shiftIn = byteIn;
                        next_st.bitCnt  = st.bitCnt + 3'h1;
                        if (st.bitCnt == `MSSP_BITS_LAST) begin
                            next_st.bitCnt = 3'h0;
                            next_st.phase  = mssp_pkg::MSSP_ADDR;
                            if (st.addr == `MSSP_ADDR_MOTION) begin
                                next_st.motFlag = motionSeen;
                            end
                        end
                    end
                end
                mssp_pkg::MSSP_RDATA: begin
                    if (fall) begin
                        next_st.dout     = st.shiftOut[7];
                        next_st.doutEn_n = 1'b0;
                        next_st.shiftOut = {st.shiftOut[6:0], 1'b0};
                    end else if (rise) begin
                        next_st.bitCnt = st.bitCnt + 3'h1;
                        if (st.bitCnt == `MSSP_BITS_LAST) begin
                            next_st.bitCnt = 3'h0;
                            if (st.burst) begin
                                // Fixed burst sequence, next slot loaded at once
                                next_st.burstIdx = st.burstIdx + 3'h1;
                                next_st.shiftOut = readByte(burstAddr(st.burstIdx + 3'h1), st);
                                if (st.burstIdx == 3'h1) begin
                                    next_st.readX = 1'b1;
                                end
                                if (st.burstIdx == 3'h2) begin
                                    next_st.readY = 1'b1;
                                end
                                if (st.burstIdx == `MSSP_BURST_LAST) begin
                                    next_st.phase = mssp_pkg::MSSP_DONE;
                                end
                            end else begin
                                next_st.phase = mssp_pkg::MSSP_ADDR;
                                if (st.addr == `MSSP_ADDR_DX) begin
                                    next_st.readX = 1'b1;
                                end
                                if (st.addr == `MSSP_ADDR_DY) begin
                                    next_st.readY = 1'b1;
                                end
                            end
                        end
                    end
                end
                mssp_pkg::MSSP_DONE: begin
                    // Refuse traffic until chip select rises; last bit stands until a fall
                    next_st.phase = mssp_pkg::MSSP_DONE;
                    if (fall) begin
                        next_st.doutEn_n = 1'b1;
                    end
                end
                default: next_st.phase = mssp_pkg::MSSP_IDLE;
            endcase
        end
        // Both displacements read clears the flag; new motion wins
        if (next_st.readX && next_st.readY && !motionSeen) begin
            next_st.motFlag = 1'b0;
            next_st.readX   = 1'b0;
            next_st.readY   = 1'b0;
        end
        next_st.motOut_n = !next_st.motFlag;
        if (csRise) begin
            next_st.bitCnt = 3'h0;
        end
        if (srst) begin
            next_st          = '0;
            next_st.csSync   = 2'h3;
            next_st.csPrev   = 1'b1;
            next_st.phase    = mssp_pkg::MSSP_IDLE;
            next_st.doutEn_n = 1'b1;
            next_st.motOut_n = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clkEn || srst) begin
            st <= next_st;
        end
    end

    // ************************************************
    // Power management
    // ************************************************
    mssp_power uPower (
        .ref_clk    (ref_clk),
        .srst       (srst),
        .clkEn      (clkEn),
        .motionSeen (motionSeen),
        .reported   (st.readX || st.readY),
        .captureReq (pwrCap),
        .laserOn    (pwrLaser),
        .powerLevel (pwrLevel)
    );

    // Registered copies so every output leaves a flop
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            laserReg <= 1'b0;
            capReg   <= 1'b0;
            levelReg <= 4'h1;
        end else if (clkEn) begin
            laserReg <= pwrLaser;
            capReg   <= pwrCap;
            levelReg <= pwrLevel;
        end
    end

    assign serDataOut     = st.dout;
    assign serDataOutEn_n = st.doutEn_n;
    assign motion_n       = st.motOut_n;
    assign laserOn        = laserReg;
    assign captureReq     = capReg;
    assign powerLevel     = levelReg;
endmodule

// ===== core/mssp_power.sv
// Rest level downshift, motion polling and laser flash control
`timescale 1ns/100ps
`include "mssp_defs.svh"
module mssp_power #(
    parameter logic [39:0] DSHIFT1_CYC = 40'(`MSSP_DSHIFT1_MS * `MSSP_CYC_PER_MS),
    parameter logic [39:0] DSHIFT2_CYC = 40'(64'(`MSSP_DSHIFT2_MS) * `MSSP_CYC_PER_MS),
    parameter logic [39:0] DSHIFT3_CYC = 40'(64'(`MSSP_DSHIFT3_MS) * `MSSP_CYC_PER_MS),
    parameter logic [39:0] POLL1_CYC   = 40'(`MSSP_POLL1_MS * `MSSP_CYC_PER_MS),
    parameter logic [39:0] POLL2_CYC   = 40'(`MSSP_POLL2_MS * `MSSP_CYC_PER_MS),
    parameter logic [39:0] POLL3_CYC   = 40'(64'(`MSSP_POLL3_MS) * `MSSP_CYC_PER_MS)
) (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  srst,
    input  wire logic                  clkEn,
    // Sensor side
    input  wire logic                  motionSeen,
    input  wire logic                  reported,
    output logic                       captureReq,
    output logic                       laserOn,
    output mssp_pkg::mssp_pwr_type     powerLevel
);
    typedef struct packed {
        mssp_pkg::mssp_pwr_type level;
        logic [39:0]            idle;
        logic [39:0]            poll;
        logic [15:0]            flash;
        logic                   cap;
    } mssp_pwrst_type;

    mssp_pwrst_type st;
    mssp_pwrst_type next_st;

    // Poll period of a level; full rate captures every cycle
    function automatic logic [39:0] pollOf(input mssp_pkg::mssp_pwr_type l);
        case (l)
            mssp_pkg::MSSP_REST1: pollOf = POLL1_CYC;
            mssp_pkg::MSSP_REST2: pollOf = POLL2_CYC;
            mssp_pkg::MSSP_REST3: pollOf = POLL3_CYC;
            default:              pollOf = 40'h0000000001;
        endcase
    endfunction

    always_comb begin
        next_st     = st;
        next_st.cap = 1'b0;
        if (motionSeen) begin
            // Motion wakes to full rate before displacement is reported
            next_st.level = mssp_pkg::MSSP_RUN;
            next_st.idle  = 40'h0000000000;
        end else if (reported) begin
            next_st.idle = 40'h0000000000;
        end else begin
            next_st.idle = st.idle + 40'h0000000001;
            case (st.level)
                mssp_pkg::MSSP_RUN: begin
                    if (st.idle >= DSHIFT1_CYC) begin
                        next_st.level = mssp_pkg::MSSP_REST1;
                        next_st.idle  = 40'h0000000000;
                    end
                end
                mssp_pkg::MSSP_REST1: begin
                    if (st.idle >= DSHIFT2_CYC) begin
                        next_st.level = mssp_pkg::MSSP_REST2;
                        next_st.idle  = 40'h0000000000;
                    end
                end
                mssp_pkg::MSSP_REST2: begin
                    if (st.idle >= DSHIFT3_CYC) begin
                        next_st.level = mssp_pkg::MSSP_REST3;
                        next_st.idle  = 40'h0000000000;
                    end
                end
                mssp_pkg::MSSP_REST3: begin
                    next_st.idle = st.idle;
                end
                default: next_st.level = mssp_pkg::MSSP_RUN;
            endcase
        end
        // Poll at the period of the current level
        if (st.poll + 40'h0000000001 >= pollOf(st.level)) begin
            next_st.poll  = 40'h0000000000;
            next_st.cap   = 1'b1;
            next_st.flash = `MSSP_FLASH_CYC;
        end else begin
            next_st.poll = st.poll + 40'h0000000001;
            if (st.flash != 16'h0000) begin
                next_st.flash = st.flash - 16'h0001;
            end
        end
        if (srst) begin
            next_st       = '0;
            next_st.level = mssp_pkg::MSSP_RUN;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (clkEn || srst) begin
            st <= next_st;
        end
    end

    // Laser lit only during a capture flash
    assign laserOn    = st.flash != 16'h0000;
    assign captureReq = st.cap;
    assign powerLevel = st.level;
endmodule

// ===== verification/mssp_host.sv
// Host controller model that masters the serial link of the sensor port
`timescale 1ns/100ps
`include "mssp_defs.svh"
module mssp_host (
    // Serial link pins
    output logic      chip_select_low,
    output logic      serClk,
    output logic      serDataIn,
    input  wire logic serDataOut,
    input  wire logic serDataOutEn_n
);
    localparam realtime HALF = 62.5;
    logic [7:0] rxByte  = 8'h00;
    logic       drove   = 1'b0;
    logic       lastOut = 1'b0;
    event       rxDone;

    // Clock idles high and stands still outside frames, except during noise
    initial begin
        chip_select_low = 1'b1;
        serClk = 1'b1;
        serDataIn = 1'b0;
    end

    // Out bit is taken at the rising edge; a released line shows no stale value
    task automatic bit_cycle(input logic d);
        serClk = 1'b0;
        serDataIn = d;
        #(HALF);
        lastOut = serDataOutEn_n ? ~lastOut : serDataOut;
        drove = drove | ~serDataOutEn_n;
        serClk = 1'b1;
        #(HALF);
    endtask
    task automatic xfer(input logic [7:0] tx);
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(tx[i]);
            rxByte[i] = lastOut;
        end
        serDataIn = ~serDataIn;
    endtask
    task automatic open_frame();
        #1.3;
        chip_select_low = 1'b0;
        #150;
        drove = 1'b0;
    endtask
    task automatic close_frame(input realtime hold);
        #(hold);
        chip_select_low = 1'b1;
        #600;
    endtask
    task automatic read(input logic [6:0] addr);
        open_frame();
        xfer({1'b0, addr});
        #4000;
        xfer(8'h00);
        ->rxDone;
        close_frame(150);
    endtask
    task automatic write(input logic [6:0] addr, input logic [7:0] data);
        open_frame();
        xfer({1'b1, addr});
        xfer(data);
        close_frame(20000);
        #10000;
    endtask
    task automatic abort_read(input logic [6:0] addr);
        open_frame();
        xfer({1'b0, addr});
        #4000;
        repeat (4) bit_cycle(1'b0);
        close_frame(30);
        #4000;
    endtask
    task automatic burst(input int n);
        open_frame();
        xfer({1'b0, `MSSP_ADDR_BURST});
        #4000;
        repeat (n) begin
            xfer(8'h00);
            ->rxDone;
        end
        drove = 1'b0;
        xfer(8'h00);
        close_frame(150);
    endtask
    // Deliberate clocking while deselected
    task automatic noise();
        drove = 1'b0;
        repeat (16) bit_cycle(~serDataIn);
    endtask
endmodule

// ===== verification/mssp_port_props.sv
// Assertion checker for the motion sensor serial port
`timescale 1ns/100ps
module mssp_port_props (
    // Clock, reset and enable
    input wire logic       ref_clk,
    input wire logic       srst,
    input wire logic       clkEn,
    // Serial link pins
    input wire logic       chip_select_low,
    input wire logic       serClk,
    input wire logic       serDataIn,
    input wire logic       serDataOut,
    input wire logic       serDataOutEn_n,
    // Motion indication and laser
    input wire logic       motion_n,
    input wire logic       laserOn,
    // Navigation core side
    input wire logic       motionSeen,
    input wire logic [7:0] deltaX,
    input wire logic [7:0] deltaY,
    input wire logic [7:0] surfQual,
    input wire logic       captureReq,
    input wire logic [3:0] powerLevel
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    // Six cycles cover the two-flop sync plus the edge detect
    sequence deselHeld;
        chip_select_low [*6];
    endsequence
    sequence clkHighHeld;
        serClk [*6];
    endsequence

    a_reset_idle: assert property (@(posedge ref_clk) disable iff (1'b0)
        srst |=> (serDataOutEn_n && motion_n && !laserOn && !captureReq && powerLevel == 4'h1))
        else $error("outputs not idle after reset");
    a_desel_release: assert property (deselHeld |-> serDataOutEn_n)
        else $error("data out driven while deselected");
    a_sel_abort: assert property ($rose(chip_select_low) |-> ##[1:6] serDataOutEn_n)
        else $error("data out not released after select rise");
    a_out_stable: assert property (clkHighHeld ##1
        (serClk && !serDataOutEn_n && !$past(serDataOutEn_n)) |-> $stable(serDataOut))
        else $error("data out changed while serial clock high");
    a_drive_on_fall: assert property ($fell(serDataOutEn_n) |-> !serClk && !chip_select_low)
        else $error("data out enabled outside a host falling edge");
    a_motion_set: assert property (motionSeen && clkEn |-> ##[1:3] !motion_n)
        else $error("motion output not lowered after new motion");
    a_clear_cause: assert property ($rose(motion_n) |-> serClk && !chip_select_low)
        else $error("motion output raised without a serial access");
    a_laser_cause: assert property ($rose(laserOn) |->
        captureReq || $past(captureReq) || $past(captureReq, 2))
        else $error("laser lit without a capture request");
    a_power_wake: assert property (motionSeen |-> ##[1:4] (powerLevel == 4'h1))
        else $error("motion did not return full rate");
    a_power_onehot: assert property ($onehot(powerLevel))
        else $error("power level not one-hot");
endmodule

bind mssp_port mssp_port_props chk (
    .ref_clk(ref_clk), .srst(srst), .clkEn(clkEn), .chip_select_low(chip_select_low),
    .serClk(serClk), .serDataIn(serDataIn), .serDataOut(serDataOut),
    .serDataOutEn_n(serDataOutEn_n), .motion_n(motion_n), .laserOn(laserOn),
    .motionSeen(motionSeen), .deltaX(deltaX), .deltaY(deltaY), .surfQual(surfQual),
    .captureReq(captureReq), .powerLevel(powerLevel)
);

// ===== verification/tb.sv
// Self-checking testbench of the motion sensor serial port
`timescale 1ns/100ps
`include "mssp_defs.svh"
module tb;
    logic        ref_clk    = 1'b0;
    logic        srst       = 1'b1;
    logic        clkEn      = 1'b1;
    logic        motionSeen = 1'b0;
    logic [7:0]  deltaX     = 8'h00;
    logic [7:0]  deltaY     = 8'h00;
    logic [7:0]  surfQual   = 8'h00;
    wire logic   chip_select_low, serClk, serDataIn, serDataOut, serDataOutEn_n;
    wire logic   motion_n, laserOn, captureReq;
    wire logic [3:0] powerLevel;
    logic [7:0]  expQ[$];
    logic [7:0]  dx, dy, sq;
    int          failures   = 0;
    int          nChecks    = 0;
    int          cycles     = 0;

    always #2.5 ref_clk = ~ref_clk;

    mssp_port uut (
        .ref_clk(ref_clk), .srst(srst), .clkEn(clkEn), .chip_select_low(chip_select_low),
        .serClk(serClk), .serDataIn(serDataIn), .serDataOut(serDataOut),
        .serDataOutEn_n(serDataOutEn_n), .motion_n(motion_n), .laserOn(laserOn),
        .motionSeen(motionSeen), .deltaX(deltaX), .deltaY(deltaY), .surfQual(surfQual),
        .captureReq(captureReq), .powerLevel(powerLevel)
    );
    mssp_host host (
        .chip_select_low(chip_select_low), .serClk(serClk), .serDataIn(serDataIn),
        .serDataOut(serDataOut), .serDataOutEn_n(serDataOutEn_n)
    );

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        nChecks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", nChecks, failures);
        if (failures == 0 && nChecks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic new_motion();
        @(negedge ref_clk);
        dx = 8'($urandom);
        dy = 8'($urandom);
        sq = 8'($urandom);
        deltaX = dx;
        deltaY = dy;
        surfQual = sq;
        motionSeen = 1'b1;
        @(negedge ref_clk);
        motionSeen = 1'b0;
        repeat (4) @(negedge ref_clk);
        check("motion low", {7'h00, motion_n}, 8'h00);
        check("power run", {4'h0, powerLevel}, 8'h01);
    endtask

    // Each returned byte takes the oldest note
    always @(host.rxDone) begin
        check("read data", host.rxByte, expQ.size() > 0 ? expQ.pop_front() : 8'hXX);
    end

    // Ceiling is about twice the expected run
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            $display("[FAIL] run length expected done seen hang");
            tally_and_finish();
        end
    end

    initial begin
        void'($urandom(32'hD3F6));
        repeat (4) @(negedge ref_clk);
        srst = 1'b0;
        repeat (8) @(negedge ref_clk);
        check("enable idle", {7'h00, serDataOutEn_n}, 8'h01);
        check("motion idle", {7'h00, motion_n}, 8'h01);
        check("power idle", {4'h0, powerLevel}, 8'h01);
        expQ.push_back(8'h00);
        host.read(7'h10);
        expQ.push_back(8'h00);
        host.read(`MSSP_ADDR_MOTION);
        $display("test idle reads done");
        new_motion();
        expQ.push_back(dx);
        host.read(`MSSP_ADDR_DX);
        check("motion after x", {7'h00, motion_n}, 8'h00);
        expQ.push_back(dy);
        host.read(`MSSP_ADDR_DY);
        check("motion after y", {7'h00, motion_n}, 8'h01);
        $display("test motion reads done");
        new_motion();
        host.write(`MSSP_ADDR_DX, 8'($urandom));
        check("motion kept", {7'h00, motion_n}, 8'h00);
        host.write(`MSSP_ADDR_MOTION, 8'($urandom));
        check("motion cleared", {7'h00, motion_n}, 8'h01);
        $display("test writes done");
        new_motion();
        host.abort_read(`MSSP_ADDR_DX);
        check("abort release", {7'h00, serDataOutEn_n}, 8'h01);
        host.noise();
        check("deselect drive", {7'h00, host.drove}, 8'h00);
        expQ.push_back(dx);
        host.read(`MSSP_ADDR_DX);
        expQ.push_back(dy);
        host.read(`MSSP_ADDR_DY);
        check("motion abort", {7'h00, motion_n}, 8'h01);
        $display("test abort done");
        new_motion();
        expQ = {8'h80, dx, dy, sq, 8'h00, 8'h00, 8'h00};
        host.burst(7);
        check("burst lockout", {7'h00, host.drove}, 8'h00);
        expQ.push_back(8'h00);
        host.read(7'h10);
        $display("test burst done");
        // Motion offered while the enable is low must be lost
        @(negedge ref_clk);
        clkEn = 1'b0;
        deltaX = 8'($urandom);
        motionSeen = 1'b1;
        @(negedge ref_clk);
        motionSeen = 1'b0;
        repeat (4) @(negedge ref_clk);
        check("motion frozen", {7'h00, motion_n}, 8'h01);
        check("capture run", {7'h00, captureReq}, 8'h01);
        check("laser run", {7'h00, laserOn}, 8'h01);
        clkEn = 1'b1;
        repeat (4) @(negedge ref_clk);
        check("motion still idle", {7'h00, motion_n}, 8'h01);
        $display("test freeze done");
        tally_and_finish();
    end
endmodule
